/* File: psfl_pkg.sv */
// Shared constants and types for the power-up strap loader
package psfl_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int PULSE_NS = 75;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [4:0] PULSE_LAST = 5'(PULSE_CYC - 1);
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_ACTIVE_LO = 8'h04;
   localparam logic [7:0] OFF_ACTIVE_HI = 8'h08;
   localparam logic [7:0] OFF_BUF_LO = 8'h0C;
   localparam logic [7:0] OFF_BUF_HI = 8'h10;
   localparam logic [7:0] OFF_CONTROL = 8'h14;
   localparam int CTRL_UPDATE_BIT = 0;
   localparam int CTRL_RESTART_BIT = 1;
   localparam int STAT_PULSE_BIT = 4;
   localparam int STAT_MULT_LSB = 8;
   // ---------------------------------------------------------------
   // Reset values and settings
   // ---------------------------------------------------------------
   localparam logic [5:0] PLL_MULT_XTAL = 6'h28;
   localparam logic [5:0] PLL_MULT_RST = 6'h00;
   localparam logic [47:0] TUNING_RST = 48'h0000_0000_0000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [6:0] SYNC_RST = 7'h40;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic clk_direct;
      logic [2:0] sel;
   } psfl_cfg_s;
   localparam psfl_cfg_s CFG_RST = '{clk_direct: 1'b0, sel: 3'h0};
   // Strap code to upper tuning word
   function automatic logic [15:0] tuning_rom(input logic [2:0] code);
      unique case (code)
         3'h0: tuning_rom = 16'h0000;
         3'h1: tuning_rom = 16'h09F4;
         3'h2: tuning_rom = 16'h0D45;
         3'h3: tuning_rom = 16'h0FBA;
         3'h4: tuning_rom = 16'h13E8;
         3'h5: tuning_rom = 16'h1797;
         3'h6: tuning_rom = 16'h1F75;
         3'h7: tuning_rom = 16'h27D0;
      endcase
   endfunction
   // Byte-lane merge for register writes
   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] strb);
      merge_strb = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge_strb[i*8 +: 8] = val[i*8 +: 8];
         end
      end
   endfunction
endpackage

/* File: psfl_loader.sv */
// Power-up strap sampler, reset pulse generator and tuning word loader
// Operation
// - Both supply monitors going valid after power-up starts one internal reset pulse of at least 75 ns (19 cycles, 76 ns at 250 MHz).
// - The four strap pins are released to high impedance as the pulse starts and stay so until it ends.
// - The strap levels are captured into a 4-bit configuration register as the pulse ends.
// - An asserted external reset pin starts the same pulse, release and capture sequence.
// - A fixed table of eight 16-bit tuning words is indexed by the first three strap bits.
// - The selected word goes straight into the active tuning word without an update command.
// - The fourth strap bit picks direct clock input when 1 and crystal with multiplier when 0.
// - In crystal with multiplier mode the multiplier factor starts at forty.
// - Code zero gives zero output frequency and the others rise up to about 155.5 MHz at 1 GHz.
// - Buffered tuning writes reach the active word only on an update command.
`timescale 1ns/1ps
`default_nettype none
module psfl_loader (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic supply_3v3_ok,
   input wire logic supply_1v8_ok,
   input wire logic ext_reset_n,
   input wire logic [3:0] strap_in,
   output logic [3:0] strap_out,
   output logic [3:0] strap_oe_n,
   output logic reset_pulse,
   output logic [47:0] active_tuning_word_reg,
   output psfl_pkg::psfl_cfg_s strap_config_reg,
   output logic clock_direct_mode,
   output logic [5:0] pll_mult_factor,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [6:0] sync1_reg, sync2_reg, sync3_reg, stable_reg;
   logic power_seen_reg, ext_prev_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= psfl_pkg::SYNC_RST;
         sync2_reg <= psfl_pkg::SYNC_RST;
         sync3_reg <= psfl_pkg::SYNC_RST;
         stable_reg <= psfl_pkg::SYNC_RST;
      end else if (clk_en) begin
         sync1_reg <= {ext_reset_n, supply_1v8_ok, supply_3v3_ok, strap_in};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         stable_reg <= (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg ^ sync3_reg));
      end
   end
   // ---------------------------------------------------------------
   // Trigger detection
   // ---------------------------------------------------------------
   logic restart_reg;
   logic power_trig, ext_trig, trig;
   assign power_trig = stable_reg[4] && stable_reg[5] && !power_seen_reg;
   assign ext_trig = ext_prev_reg && !stable_reg[6];
   assign trig = power_trig || ext_trig || restart_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_seen_reg <= 1'b0;
         ext_prev_reg <= 1'b1;
      end else if (clk_en) begin
         ext_prev_reg <= stable_reg[6];
         if (power_trig) begin
            power_seen_reg <= 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // Reset pulse, strap capture and clock mode
   // ---------------------------------------------------------------
   logic [4:0] pulse_cnt_reg;
   logic pulse_end;
   assign pulse_end = reset_pulse && pulse_cnt_reg == psfl_pkg::PULSE_LAST;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_pulse <= 1'b0;
         pulse_cnt_reg <= 5'h00;
         strap_oe_n <= 4'hF;
         strap_config_reg <= psfl_pkg::CFG_RST;
      end else if (clk_en) begin
         if (trig) begin
            reset_pulse <= 1'b1;
            pulse_cnt_reg <= 5'h00;
            strap_oe_n <= 4'hF;
         end else if (pulse_end) begin
            reset_pulse <= 1'b0;
            strap_oe_n <= 4'h0;
            strap_config_reg <= psfl_pkg::psfl_cfg_s'(stable_reg[3:0]);
         end else if (reset_pulse) begin
            pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_direct_mode <= 1'b0;
         pll_mult_factor <= psfl_pkg::PLL_MULT_RST;
         strap_out <= 4'h0;
      end else if (clk_en && pulse_end) begin
         clock_direct_mode <= stable_reg[3];
         pll_mult_factor <= stable_reg[3] ? psfl_pkg::PLL_MULT_RST : psfl_pkg::PLL_MULT_XTAL;
         strap_out <= stable_reg[3:0];
      end
   end
   // ---------------------------------------------------------------
   // Register write channel
   // ---------------------------------------------------------------
   logic aw_held_reg, w_held_reg, wr_fire;
   logic [7:0] wr_addr_reg;
   logic [31:0] wr_data_reg;
   logic [3:0] wr_strb_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         wr_data_reg <= psfl_pkg::WORD_RST;
         wr_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= psfl_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held_reg <= 1'b1;
            wr_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held_reg <= 1'b1;
            wr_data_reg <= s_axi_wdata;
            wr_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr_reg == psfl_pkg::OFF_BUF_LO || wr_addr_reg == psfl_pkg::OFF_BUF_HI ||
                            wr_addr_reg == psfl_pkg::OFF_CONTROL) ? psfl_pkg::RESP_OKAY : psfl_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // Buffered and active tuning word, commands
   // ---------------------------------------------------------------
   logic [31:0] buf_lo_reg, buf_hi_reg;
   logic update_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buf_lo_reg <= psfl_pkg::WORD_RST;
         buf_hi_reg <= psfl_pkg::WORD_RST;
         update_reg <= 1'b0;
         restart_reg <= 1'b0;
      end else if (clk_en) begin
         update_reg <= 1'b0;
         restart_reg <= 1'b0;
         if (wr_fire) begin
            unique case (wr_addr_reg)
               psfl_pkg::OFF_BUF_LO: begin
                  buf_lo_reg <= psfl_pkg::merge_strb(buf_lo_reg, wr_data_reg, wr_strb_reg);
               end
               psfl_pkg::OFF_BUF_HI: begin
                  buf_hi_reg <= psfl_pkg::merge_strb(buf_hi_reg, wr_data_reg, wr_strb_reg) & 32'h0000_FFFF;
               end
               psfl_pkg::OFF_CONTROL: begin
                  update_reg <= wr_strb_reg[0] && wr_data_reg[psfl_pkg::CTRL_UPDATE_BIT];
                  restart_reg <= wr_strb_reg[0] && wr_data_reg[psfl_pkg::CTRL_RESTART_BIT];
               end
               default: begin
               end
            endcase
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_tuning_word_reg <= psfl_pkg::TUNING_RST;
      end else if (clk_en) begin
         if (pulse_end) begin
            active_tuning_word_reg <= {psfl_pkg::tuning_rom(stable_reg[2:0]), 32'h0000_0000};
         end else if (update_reg) begin
            active_tuning_word_reg <= {buf_hi_reg[15:0], buf_lo_reg};
         end
      end
   end
   // ---------------------------------------------------------------
   // Register read channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= psfl_pkg::WORD_RST;
         s_axi_rresp <= psfl_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= psfl_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
               psfl_pkg::OFF_STATUS: begin
                  s_axi_rdata <= {18'h0_0000, pll_mult_factor, 3'h0, reset_pulse, strap_config_reg};
               end
               psfl_pkg::OFF_ACTIVE_LO: begin
                  s_axi_rdata <= active_tuning_word_reg[31:0];
               end
               psfl_pkg::OFF_ACTIVE_HI: begin
                  s_axi_rdata <= {16'h0000, active_tuning_word_reg[47:32]};
               end
               psfl_pkg::OFF_BUF_LO: begin
                  s_axi_rdata <= buf_lo_reg;
               end
               psfl_pkg::OFF_BUF_HI: begin
                  s_axi_rdata <= buf_hi_reg;
               end
               psfl_pkg::OFF_CONTROL: s_axi_rdata <= psfl_pkg::WORD_RST;
               default: begin
                  s_axi_rdata <= psfl_pkg::WORD_RST;
                  s_axi_rresp <= psfl_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !clk_en);
   property p_pulse_len;
      $rose(reset_pulse) && !trig |-> reset_pulse [*8] ##11 reset_pulse ##1 !reset_pulse;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
   property p_float;
      reset_pulse |-> strap_oe_n == 4'hF;
   endproperty
   a_float: assert property (p_float) else $error("strap pins driven during pulse");
   property p_capture;
      $fell(reset_pulse) |-> strap_config_reg == psfl_pkg::psfl_cfg_s'($past(stable_reg[3:0])) && strap_oe_n == 4'h0;
   endproperty
   a_capture: assert property (p_capture) else $error("strap capture mismatch");
   property p_ext;
      ext_trig |=> reset_pulse && strap_oe_n == 4'hF && pulse_cnt_reg == 5'h00;
   endproperty
   a_ext: assert property (p_ext) else $error("external reset did not start pulse");
   property p_load;
      $fell(reset_pulse) |-> active_tuning_word_reg == {psfl_pkg::tuning_rom(strap_config_reg.sel), 32'h0000_0000};
   endproperty
   a_load: assert property (p_load) else $error("tuning word not loaded from table");
   property p_mode;
      $fell(reset_pulse) |-> clock_direct_mode == strap_config_reg.clk_direct;
   endproperty
   a_mode: assert property (p_mode) else $error("clock mode mismatch");
   property p_mult;
      $fell(reset_pulse) && !clock_direct_mode |-> pll_mult_factor == psfl_pkg::PLL_MULT_XTAL;
   endproperty
   a_mult: assert property (p_mult) else $error("multiplier not forty");
   property p_zero;
      $fell(reset_pulse) && strap_config_reg.sel == 3'h0 |-> active_tuning_word_reg == psfl_pkg::TUNING_RST;
   endproperty
   a_zero: assert property (p_zero) else $error("code zero not zero frequency");
   property p_buffered;
      $changed(active_tuning_word_reg) |-> $past(update_reg) || $past(pulse_end);
   endproperty
   a_buffered: assert property (p_buffered) else $error("active word changed without update");
   c_power: cover property (power_trig ##1 reset_pulse);
   c_ext: cover property (ext_trig ##1 reset_pulse);
   c_update: cover property (update_reg ##1 $changed(active_tuning_word_reg));
   c_direct: cover property ($fell(reset_pulse) && clock_direct_mode);
endmodule
`default_nettype wire

/* File: psfl_strap_pulls.sv */
// Board pull resistors on the four strap pins
`timescale 1ns/1ps
`default_nettype none
module psfl_strap_pulls (
   input wire logic [3:0] pull_level,
   input wire logic [3:0] strap_out,
   input wire logic [3:0] strap_oe_n,
   output logic [3:0] strap_in
);
   // ---------------------------------------------------------------
   // Pin level: driver wins, else the pull resistor
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         strap_in[i] = strap_oe_n[i] ? pull_level[i] : strap_out[i];
      end
   end
endmodule
`default_nettype wire

/* File: psfl_loader_test.sv */
// Self-checking testbench for the strap loader
`timescale 1ns/1ps
`default_nettype none
module psfl_loader_test;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam int PULSE_EXP = (75 + 4 - 1) / 4;
   localparam logic [15:0] ROM_EXP [8] = '{16'h0000, 16'h09F4, 16'h0D45, 16'h0FBA,
                                           16'h13E8, 16'h1797, 16'h1F75, 16'h27D0};
   logic aclk, aresetn, clk_en, ok33, ok18, ext_reset_n;
   logic [3:0] pull_lvl, strap_in, strap_out, strap_oe_n;
   logic reset_pulse, clock_direct_mode;
   logic [47:0] tuning;
   psfl_pkg::psfl_cfg_s cfg;
   logic [5:0] mult;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rr;
   int fails, n_tests;

   psfl_strap_pulls pulls (.pull_level(pull_lvl), .strap_out(strap_out), .strap_oe_n(strap_oe_n),
                           .strap_in(strap_in));
   psfl_loader dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .supply_3v3_ok(ok33),
      .supply_1v8_ok(ok18), .ext_reset_n(ext_reset_n), .strap_in(strap_in), .strap_out(strap_out),
      .strap_oe_n(strap_oe_n), .reset_pulse(reset_pulse), .active_tuning_word_reg(tuning),
      .strap_config_reg(cfg), .clock_direct_mode(clock_direct_mode), .pll_mult_factor(mult),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (fails == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Waits for one strap pulse, measures it and checks what it loaded
   task automatic pulse_check(input logic [3:0] lvl);
      int n;
      n = 0;
      while (reset_pulse !== 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      check(strap_oe_n, 4'hF);
      n = 0;
      while (reset_pulse === 1'b1 && n < 60) begin
         @(posedge aclk);
         n++;
      end
      check(n, PULSE_EXP);
      check(cfg, lvl);
      check(strap_out, lvl);
      check(tuning, {ROM_EXP[lvl[2:0]], 32'h0000_0000});
      check(clock_direct_mode, lvl[3]);
      check(mult, lvl[3] ? 6'h00 : 6'h28);
      check(strap_oe_n, 4'h0);
   endtask

   task automatic ext_reset(input logic [3:0] lvl);
      @(posedge aclk);
      pull_lvl <= lvl;
      ext_reset_n <= 1'b0;
      repeat (2) @(posedge aclk);
      ext_reset_n <= 1'b1;
      pulse_check(lvl);
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      tally_and_finish();
   end

   initial begin
      fails = 0;
      n_tests = 0;
      {aresetn, ok33, ok18, awvalid, wvalid, bready, arvalid, rready} = '0;
      clk_en = 1'b1;
      ext_reset_n = 1'b1;
      pull_lvl = 4'h5;
      {awaddr, araddr, wdata, wstrb} = '0;
      repeat (16) @(posedge aclk);
      check(strap_oe_n, 4'hF);
      aresetn <= 1'b1;
      ok33 <= 1'b1;
      ok18 <= 1'b1;
      pulse_check(4'h5);
      for (int c = 0; c < 16; c++) begin
         ext_reset(4'(c));
      end
      axi_write(8'h0C, 32'h1234_5678, 4'hF, rr);
      check(rr, 2'h0);
      axi_write(8'h10, 32'h0000_ABCD, 4'hF, rr);
      axi_read(8'h08, rd, rr);
      check(rd, 32'h0000_27D0);
      axi_write(8'h0C, 32'hFFFF_FFFF, 4'h1, rr);
      axi_read(8'h0C, rd, rr);
      check(rd, 32'h1234_56FF);
      axi_write(8'h14, 32'h0000_0001, 4'h1, rr);
      repeat (3) @(posedge aclk);
      check(tuning, 48'hABCD_1234_56FF);
      ext_reset(4'h2);
      axi_read(8'h00, rd, rr);
      check(rd, 32'h0000_2802);
      axi_read(8'h04, rd, rr);
      check(rd, 32'h0000_0000);
      axi_read(8'h18, rd, rr);
      check({rr, rd}, {2'h2, 32'h0000_0000});
      // Pin reset ignored while the clock enable is low
      clk_en <= 1'b0;
      ext_reset_n <= 1'b0;
      repeat (6) @(posedge aclk);
      ext_reset_n <= 1'b1;
      repeat (6) @(posedge aclk);
      clk_en <= 1'b1;
      repeat (8) @(posedge aclk);
      check(reset_pulse, 1'b0);
      axi_write(8'h04, 32'hFFFF_FFFF, 4'hF, rr);
      check(rr, 2'h2);
      check(tuning, {ROM_EXP[2], 32'h0000_0000});
      // Restart command repeats the strap sequence
      pull_lvl <= 4'hB;
      axi_write(8'h14, 32'h0000_0002, 4'h1, rr);
      pulse_check(4'hB);
      tally_and_finish();
   end
endmodule
`default_nettype wire
